/* File: hdl/timer_pwm_cfg.svh */
`ifndef TIMER_PWM_CFG_SVH
`define TIMER_PWM_CFG_SVH
`define TP_ADDR_STATUS   3'h0
`define TP_ADDR_MODULO   3'h1
`define TP_ADDR_COUNTER  3'h2
`define TP_ADDR_CH0_CTRL 3'h3
`define TP_ADDR_CH1_CTRL 3'h4
`define TP_ADDR_CH0_CMP  3'h5
`define TP_ADDR_CH1_CMP  3'h6
`define TP_ST_FLAG       7
`define TP_ST_IRQ_EN     6
`define TP_ST_HALT       5
`define TP_ST_RESET      4
`define TP_ST_PS_HI      2
`define TP_CC_FLAG       7
`define TP_CC_IRQ_EN     6
`define TP_CC_MODE_HI    5
`define TP_CC_MODE_LO    4
`define TP_CC_EDGE_HI    3
`define TP_CC_EDGE_LO    2
`define TP_CC_TOGGLE     1
`define TP_CC_MAX        0
`define TP_MODULO_RST    16'hffff
`define TP_COUNT_ZERO    16'h0000
`define TP_PS_MAX        3'h6
`endif

/* File: hdl/timer_pwm_pkg.sv */
package timer_pwm_pkg;
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;
  typedef enum logic [1:0] {
    SEL_CH0,
    SEL_CH1
  } bank_e;
endpackage

/* File: hdl/timer_pwm_channels.sv */
// Function
// R1: Unbuffered compare writes take effect at once, with no shadow copy.
// R2: A compare value already passed yields no compare in that period.
// R3: Channel flag sets at end of pulse; software shortens width there.
// R4: Overflow flag sets at period end; software lengthens width there.
// R5: Software should not choose toggle-on-compare in PWM.
// R6: Buffered bit on channel 0 links channels; output on channel 0 pin.
// R7: Buffered: last written compare set takes control at next overflow.
// R8: Linked: channel 0 control governs output, channel 1 pin released.
// R9: Software must not write the active compare set when buffered.
// R10: Mode field 0:1 unbuffered, 1:0 buffered; buffered bit wins.
// R11: Edge field 1:0 clears, 1:1 sets output on compare.
// R12: Toggle-on-overflow toggles output; cleared gives 0 percent duty.
// R13: Max duty bit with toggle cleared holds output at 100 percent.
// R14: Software init: halt, reset, modulo, width, mode bits, then run.
// R15: Overflow flag sets on rollover; irq only when enabled.
// R16: Channel flag sets on compare; irq only when enabled.
// R17: In wait mode the timer runs and enabled irqs wake the processor.
// R18: In stop mode the timer halts keeping all state.
// R19: The counter holds while break is active.
// R20: In break, flags clear only when break clear enable is one.
// R21: An armed two-step clear survives break and completes afterwards.
// R22: At the modulo value the counter restarts from zero next tick.
// R23: Overflow clears by read while set then write 0; new set wins.
// R24: Counter reset bit clears counter and prescaler; reads as zero.
`timescale 1ns/10ps
`default_nettype none
`include "timer_pwm_cfg.svh"
module timer_pwm_channels #(
  parameter int CNT_W = 16
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   clk_en_i,
  input  wire timer_pwm_pkg::bus_req_s bus_i,
  output logic [15:0]                 rdata_o,
  input  wire logic                   wait_mode_i,
  input  wire logic                   stop_mode_i,
  input  wire logic                   break_i,
  input  wire logic                   break_clear_enable_i,
  output logic                        channel0_pin_o,
  output logic                        channel0_pin_oe_n_o,
  output logic                        channel1_pin_o,
  output logic                        channel1_pin_oe_n_o,
  output logic                        overflow_irq_o,
  output logic                        chan0_irq_o,
  output logic                        chan1_irq_o,
  output logic                        wake_o
);

  // ==========================================================
  // Parameter check
  if (CNT_W != 16)
  begin : g_bad_width
    $error("timer_pwm_channels supports CNT_W of 16 only");
  end

  // ==========================================================
  // State
  logic [15:0] modulo_r;
  logic [15:0] count_r;
  logic [5:0]  presc_r;
  logic [2:0]  ps_r;
  logic        halt_r;
  logic        ovf_irq_en_r;
  logic        ovf_flag_r;
  logic        ovf_armed_r;
  logic [7:0]  cc0_r;
  logic [7:0]  cc1_r;
  logic        ch0_armed_r;
  logic        ch1_armed_r;
  logic [15:0] cmp0_r;
  logic [15:0] cmp1_r;
  logic        pending1_r;
  timer_pwm_pkg::bank_e active_r;
  timer_pwm_pkg::bank_e last_wr_r;
  logic        out0_r;
  logic        out1_r;

  // ==========================================================
  // Decode
  function automatic logic hit(input logic [2:0] a, input logic [2:0] target);
    hit = (a == target);
  endfunction

  // Wait mode keeps the bus fenced off, so no strobe reaches the registers.
  wire bus_ok     = !wait_mode_i;                                   // R17
  wire wr         = bus_i.wr && bus_ok;
  wire rd         = bus_i.rd && bus_ok;
  wire wr_status  = wr && hit(bus_i.addr, `TP_ADDR_STATUS);
  wire rd_status  = rd && hit(bus_i.addr, `TP_ADDR_STATUS);
  wire wr_modulo  = wr && hit(bus_i.addr, `TP_ADDR_MODULO);
  wire wr_cc0     = wr && hit(bus_i.addr, `TP_ADDR_CH0_CTRL);
  wire rd_cc0     = rd && hit(bus_i.addr, `TP_ADDR_CH0_CTRL);
  wire wr_cc1     = wr && hit(bus_i.addr, `TP_ADDR_CH1_CTRL);
  wire rd_cc1     = rd && hit(bus_i.addr, `TP_ADDR_CH1_CTRL);
  wire wr_cmp0    = wr && hit(bus_i.addr, `TP_ADDR_CH0_CMP);
  wire wr_cmp1    = wr && hit(bus_i.addr, `TP_ADDR_CH1_CMP);
  wire cnt_reset  = wr_status && bus_i.wdata[`TP_ST_RESET];          // R24
  // A break with clearing disabled leaves every flag alone, armed or not.
  wire clr_ok     = !break_i || break_clear_enable_i;               // R20

  // ==========================================================
  // Mode decode
  wire linked     = cc0_r[`TP_CC_MODE_HI];                          // R6 R10
  wire ch0_cmp_en = linked || cc0_r[`TP_CC_MODE_LO];                // R10
  wire ch1_cmp_en = !linked && cc1_r[`TP_CC_MODE_LO];               // R8
  wire [15:0] cmp0_eff = (linked && active_r == timer_pwm_pkg::SEL_CH1) ? cmp1_r : cmp0_r;

  // ==========================================================
  // Counter and prescaler
  wire run        = !halt_r && !stop_mode_i && !break_i;            // R18 R19
  // Prescale code seven has no internal source, so it yields no ticks at all.
  wire [5:0] ps_mask = (6'h01 << ps_r) - 6'h01;
  wire tick       = run && ((presc_r & ps_mask) == 6'h00) && (ps_r <= `TP_PS_MAX);
  wire at_mod     = (count_r == modulo_r);
  wire ovf_ev     = tick && at_mod;                                 // R22
  // The compare is skipped in the overflow tick so toggle and forced level never fight.
  // The compare uses the live register so a new value acts at once.
  wire hit0       = tick && !at_mod && ch0_cmp_en && (count_r == cmp0_eff); // R1 R2
  wire hit1       = tick && !at_mod && ch1_cmp_en && (count_r == cmp1_r);   // R1 R2

  function automatic logic edge_out(input logic [7:0] cc, input logic cur);
    logic [1:0] e;
    e = {cc[`TP_CC_EDGE_HI], cc[`TP_CC_EDGE_LO]};
    case (e)
      2'h1:    edge_out = !cur;
      2'h2:    edge_out = 1'b0;                                     // R11
      2'h3:    edge_out = 1'b1;                                     // R11
      default: edge_out = cur;
    endcase
  endfunction

  function automatic logic pin_next(input logic [7:0] cc, input logic cur,
                                    input logic ovf, input logic cmp);
    logic v;
    v = cur;
    if (!cc[`TP_CC_TOGGLE] && cc[`TP_CC_MAX])
      v = 1'b1;                                                     // R13
    else
    begin
      if (ovf && cc[`TP_CC_TOGGLE])
        v = !v;                                                     // R12
      if (cmp)
        v = edge_out(cc, v);
    end
    pin_next = v;
  endfunction

  wire out0_nxt = pin_next(cc0_r, out0_r, ovf_ev, hit0);
  wire out1_nxt = pin_next(cc1_r, out1_r, ovf_ev, hit1);

  // ==========================================================
  // Flags: hardware set wins over a clear in the same cycle.
  wire ovf_clr  = wr_status && !bus_i.wdata[`TP_ST_FLAG] && ovf_armed_r && clr_ok; // R23 R21
  wire ovf_nxt  = ovf_ev || (ovf_flag_r && !ovf_clr);               // R15 R23
  wire ch0_clr  = wr_cc0 && !bus_i.wdata[`TP_CC_FLAG] && ch0_armed_r && clr_ok;
  wire ch1_clr  = wr_cc1 && !bus_i.wdata[`TP_CC_FLAG] && ch1_armed_r && clr_ok;
  wire ch0f_nxt = hit0 || (cc0_r[`TP_CC_FLAG] && !ch0_clr);         // R3 R16
  wire ch1f_nxt = hit1 || (cc1_r[`TP_CC_FLAG] && !ch1_clr);         // R16

  function automatic logic [7:0] cc_next(input logic [7:0] cur, input logic wr_i,
                                         input logic [15:0] d, input logic f);
    logic [7:0] v;
    v = wr_i ? d[7:0] : cur;
    v[`TP_CC_FLAG] = f;
    cc_next = v;
  endfunction

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      modulo_r     <= `TP_MODULO_RST;
      count_r      <= `TP_COUNT_ZERO;
      presc_r      <= 6'h00;
      ps_r         <= 3'h0;
      halt_r       <= 1'b1;
      ovf_irq_en_r <= 1'b0;
      ovf_flag_r   <= 1'b0;
      ovf_armed_r  <= 1'b0;
      cc0_r        <= 8'h00;
      cc1_r        <= 8'h00;
      ch0_armed_r  <= 1'b0;
      ch1_armed_r  <= 1'b0;
      cmp0_r       <= `TP_COUNT_ZERO;
      cmp1_r       <= `TP_COUNT_ZERO;
      pending1_r   <= 1'b0;
      active_r     <= timer_pwm_pkg::SEL_CH0;
      last_wr_r    <= timer_pwm_pkg::SEL_CH0;
      out0_r       <= 1'b0;
      out1_r       <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (cnt_reset)
      begin
        count_r <= `TP_COUNT_ZERO;                                  // R24
        presc_r <= 6'h00;
      end
      else if (run)
      begin
        presc_r <= presc_r + 6'h01;
        if (tick)
          count_r <= at_mod ? `TP_COUNT_ZERO : count_r + 16'h0001;  // R22
      end
      if (wr_status)
      begin
        ovf_irq_en_r <= bus_i.wdata[`TP_ST_IRQ_EN];
        halt_r       <= bus_i.wdata[`TP_ST_HALT];
        ps_r         <= bus_i.wdata[`TP_ST_PS_HI:0];
      end
      if (wr_modulo)
        modulo_r <= bus_i.wdata;
      ovf_flag_r <= ovf_nxt;
      // The first step arms only while set; the arm survives break untouched.
      if (ovf_ev || ovf_clr)
        ovf_armed_r <= 1'b0;
      else if (rd_status && ovf_flag_r)
        ovf_armed_r <= 1'b1;                                        // R21 R23
      if (hit0 || ch0_clr)
        ch0_armed_r <= 1'b0;
      else if (rd_cc0 && cc0_r[`TP_CC_FLAG])
        ch0_armed_r <= 1'b1;                                        // R21
      if (hit1 || ch1_clr)
        ch1_armed_r <= 1'b0;
      else if (rd_cc1 && cc1_r[`TP_CC_FLAG])
        ch1_armed_r <= 1'b1;
      cc0_r <= cc_next(cc0_r, wr_cc0, bus_i.wdata, ch0f_nxt);
      cc1_r <= cc_next(cc1_r, wr_cc1, bus_i.wdata, ch1f_nxt);
      if (wr_cmp0)
        cmp0_r <= bus_i.wdata;                                      // R1
      if (wr_cmp1)
        cmp1_r <= bus_i.wdata;                                      // R1
      if (wr_cmp0)
        last_wr_r <= timer_pwm_pkg::SEL_CH0;
      else if (wr_cmp1)
        last_wr_r <= timer_pwm_pkg::SEL_CH1;
      if (!linked)
      begin
        // Writes made before linking must not steer the first buffered period.
        active_r   <= timer_pwm_pkg::SEL_CH0;
        last_wr_r  <= timer_pwm_pkg::SEL_CH0;
        pending1_r <= 1'b0;
      end
      else if (ovf_ev)
      begin
        active_r   <= (wr_cmp1 || (pending1_r && !wr_cmp0)) ? timer_pwm_pkg::SEL_CH1 :
                      (wr_cmp0 ? timer_pwm_pkg::SEL_CH0 : last_wr_r); // R7
        pending1_r <= 1'b0;
      end
      else if (wr_cmp1 || wr_cmp0)
        pending1_r <= wr_cmp1;                                      // R7
      out0_r <= out0_nxt;
      out1_r <= out1_nxt;
    end
  end

  // ==========================================================
  // Read data and outputs
  logic [15:0] rdata_nxt;
  always_comb
  begin
    rdata_nxt = 16'h0000;
    case (bus_i.addr)
      `TP_ADDR_STATUS:   rdata_nxt = {8'h00, ovf_flag_r, ovf_irq_en_r, halt_r, 2'h0, ps_r};
      `TP_ADDR_MODULO:   rdata_nxt = modulo_r;
      `TP_ADDR_COUNTER:  rdata_nxt = count_r;
      `TP_ADDR_CH0_CTRL: rdata_nxt = {8'h00, cc0_r};
      `TP_ADDR_CH1_CTRL: rdata_nxt = {8'h00, cc1_r};
      `TP_ADDR_CH0_CMP:  rdata_nxt = cmp0_r;
      `TP_ADDR_CH1_CMP:  rdata_nxt = cmp1_r;
      default:           rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o             <= 16'h0000;
      channel0_pin_o      <= 1'b0;
      channel0_pin_oe_n_o <= 1'b1;
      channel1_pin_o      <= 1'b0;
      channel1_pin_oe_n_o <= 1'b1;
      overflow_irq_o      <= 1'b0;
      chan0_irq_o         <= 1'b0;
      chan1_irq_o         <= 1'b0;
      wake_o              <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rdata_o             <= rd ? rdata_nxt : 16'h0000;
      channel0_pin_o      <= out0_nxt;
      channel0_pin_oe_n_o <= !ch0_cmp_en;                           // R6
      channel1_pin_o      <= out1_nxt;
      channel1_pin_oe_n_o <= !ch1_cmp_en;                           // R8
      overflow_irq_o      <= ovf_nxt && ovf_irq_en_r;               // R15 R4
      chan0_irq_o         <= ch0f_nxt && cc0_r[`TP_CC_IRQ_EN];      // R16
      chan1_irq_o         <= ch1f_nxt && cc1_r[`TP_CC_IRQ_EN];      // R16
      wake_o              <= wait_mode_i && ((ovf_nxt && ovf_irq_en_r) ||
                             (ch0f_nxt && cc0_r[`TP_CC_IRQ_EN]) ||
                             (ch1f_nxt && cc1_r[`TP_CC_IRQ_EN]));   // R17
    end
  end

  // ==========================================================
  // Assertions
  a_ovf_sets_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R15
    clk_en_i && ovf_ev |=> ovf_flag_r) else $error("overflow flag not set");
  a_count_wraps: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R22
    clk_en_i && ovf_ev && !cnt_reset |=> count_r == `TP_COUNT_ZERO) else $error("no wrap");
  a_halt_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R18
    clk_en_i && stop_mode_i && !cnt_reset |=> $stable(count_r)) else $error("count moved");
  a_break_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R19
    clk_en_i && break_i && !cnt_reset |=> $stable(count_r)) else $error("count moved");
  a_break_keeps_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R20
    clk_en_i && break_i && !break_clear_enable_i && ovf_flag_r |=> ovf_flag_r)
    else $error("flag cleared in break");
  a_clear_needs_read: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R23
    clk_en_i && ovf_flag_r && !ovf_armed_r |=> ovf_flag_r) else $error("flag cleared unarmed");
  a_max_duty: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
    clk_en_i && cc0_r[`TP_CC_MAX] && !cc0_r[`TP_CC_TOGGLE] |=> channel0_pin_o)
    else $error("max duty not high");
  a_cmp_sets_chflag: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
    clk_en_i && hit0 |=> cc0_r[`TP_CC_FLAG]) else $error("channel flag not set");
  a_link_releases: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R8
    clk_en_i && linked |=> channel1_pin_oe_n_o) else $error("channel 1 pin driven");
  a_buf_switch: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R7
    clk_en_i && linked && pending1_r && ovf_ev && !wr_cmp0 |=> active_r == timer_pwm_pkg::SEL_CH1)
    else $error("buffer did not switch");
  // Requests reach the pins only through their enables, and wait mode shuts the bus.
  a_wait_reads_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R17
    clk_en_i && wait_mode_i |=> rdata_o == 16'h0000)
    else $error("read data leaked in wait mode");
  a_wake_on_irq: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R17
    clk_en_i && wait_mode_i && ovf_flag_r && ovf_irq_en_r |=> wake_o)
    else $error("no wake on enabled overflow");
  a_ovf_irq_masked: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R15
    clk_en_i && !ovf_irq_en_r |=> !overflow_irq_o)
    else $error("overflow request while disabled");
  a_ch0_irq_masked: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
    clk_en_i && !cc0_r[`TP_CC_IRQ_EN] |=> !chan0_irq_o)
    else $error("channel 0 request while disabled");
  a_ch1_irq_masked: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
    clk_en_i && !cc1_r[`TP_CC_IRQ_EN] |=> !chan1_irq_o)
    else $error("channel 1 request while disabled");
  a_cmp1_sets_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
    clk_en_i && hit1 |=> cc1_r[`TP_CC_FLAG])
    else $error("channel 1 flag not set");
  a_zero_duty_low: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R12
    clk_en_i && !cc0_r[`TP_CC_TOGGLE] && !cc0_r[`TP_CC_MAX] && cc0_r[`TP_CC_EDGE_HI] &&
    !cc0_r[`TP_CC_EDGE_LO] && !out0_r |=> !channel0_pin_o)
    else $error("zero duty output rose");
  a_reset_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R24
    clk_en_i && cnt_reset |=> count_r == `TP_COUNT_ZERO)
    else $error("counter not cleared");
  a_link_drives_ch0: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R6
    clk_en_i && linked |=> !channel0_pin_oe_n_o)
    else $error("channel 0 pin not driven");
  a_unbuf_write_now: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R1
    clk_en_i && wr_cmp0 |=> cmp0_r == $past(bus_i.wdata))
    else $error("compare write not taken");
  c_overflow: cover property (@(posedge clk_i) ovf_ev);
  c_compare0: cover property (@(posedge clk_i) hit0);
  c_buffer_switch: cover property (@(posedge clk_i) linked && ovf_ev && pending1_r);
  c_flag_clear: cover property (@(posedge clk_i) ovf_clr);
  c_wake: cover property (@(posedge clk_i) wake_o);

endmodule
`default_nettype wire

/* File: bench/timer_pwm_channels_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "timer_pwm_cfg.svh"
module timer_pwm_channels_tb_top;
  localparam logic [2:0] st_a  = `TP_ADDR_STATUS;
  localparam logic [2:0] mod_a = `TP_ADDR_MODULO;
  localparam logic [2:0] cnt_a = `TP_ADDR_COUNTER;
  localparam logic [2:0] c0_a  = `TP_ADDR_CH0_CTRL;
  localparam logic [2:0] c1_a  = `TP_ADDR_CH1_CTRL;
  localparam logic [2:0] p0_a  = `TP_ADDR_CH0_CMP;
  localparam logic [2:0] p1_a  = `TP_ADDR_CH1_CMP;
  logic                    clk_i;
  logic                    reset_n_i;
  logic                    clk_en_i;
  timer_pwm_pkg::bus_req_s bus_i;
  logic                    wait_mode_i, stop_mode_i, break_i, break_clear_enable_i;
  logic [15:0]             rdata_o;
  logic                    channel0_pin_o, channel0_pin_oe_n_o;
  logic                    channel1_pin_o, channel1_pin_oe_n_o;
  logic                    overflow_irq_o, chan0_irq_o, chan1_irq_o, wake_o;
  logic [15:0]             exp_q[$];
  string                   name_q[$];
  logic                    rd_pend;
  int                      mismatches;
  int                      checks;
  logic [31:0]             seed;
  logic [15:0]             a, h1, h2;
  logic [7:0]              ctl;

  timer_pwm_channels timer_pwm_channels_inst (
    .clk_i                (clk_i),
    .reset_n_i            (reset_n_i),
    .clk_en_i             (clk_en_i),
    .bus_i                (bus_i),
    .rdata_o              (rdata_o),
    .wait_mode_i          (wait_mode_i),
    .stop_mode_i          (stop_mode_i),
    .break_i              (break_i),
    .break_clear_enable_i (break_clear_enable_i),
    .channel0_pin_o       (channel0_pin_o),
    .channel0_pin_oe_n_o  (channel0_pin_oe_n_o),
    .channel1_pin_o       (channel1_pin_o),
    .channel1_pin_oe_n_o  (channel1_pin_oe_n_o),
    .overflow_irq_o       (overflow_irq_o),
    .chan0_irq_o          (chan0_irq_o),
    .chan1_irq_o          (chan1_irq_o),
    .wake_o               (wake_o)
  );

  // ==========================================================
  // Clock, scoreboard and closing
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so sample at the falling edge.
  always @(negedge clk_i)
  begin
    if (rd_pend)
      check(name_q.pop_front(), rdata_o, exp_q.pop_front());
    rd_pend = bus_i.rd;
  end

  initial
  begin
    #300000;
    mismatches++;
    complete_run();
  end

  // ==========================================================
  // Bus and measurement tasks
  task automatic bus_write(input logic [2:0] ad, input logic [15:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
  endtask

  task automatic bus_read(input logic [2:0] ad, input logic [15:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge clk_i);
    bus_i <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
  endtask

  // The output is read after the wait, so the value compared is the settled one.
  task automatic pin_chk(input string nm, input int sel, input logic e);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check(nm, {15'h0000, ((sel == 0) ? overflow_irq_o : wake_o)}, {15'h0000, e});
  endtask

  task automatic run_ovf();
    bus_write(st_a, 16'h0040);
    repeat (30) @(posedge clk_i);
    bus_write(st_a, 16'h0060);
  endtask

  // Counting over whole periods makes the total independent of the start phase.
  task automatic measure(input int sel, output logic [15:0] hi);
    hi = 16'h0000;
    repeat (20) @(posedge clk_i);
    repeat (100)
    begin
      @(negedge clk_i);
      hi = hi + {15'h0000, ((sel == 0) ? channel0_pin_o : channel1_pin_o)};
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'h43a9bccf;
    bus_i = '0;
    rd_pend = 1'b0;
    mismatches = 0;
    checks = 0;
    reset_n_i = 1'b0;
    clk_en_i = 1'b1;
    wait_mode_i = 1'b0;
    stop_mode_i = 1'b0;
    break_i = 1'b0;
    break_clear_enable_i = 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    bus_read(st_a, 16'h0020, "status reset");
    bus_read(mod_a, `TP_MODULO_RST, "modulo reset");
    bus_read(cnt_a, `TP_COUNT_ZERO, "counter reset");
    bus_write(3'h7, 16'($random(seed)));
    bus_read(3'h7, 16'h0000, "unmapped");
    bus_write(mod_a, 16'h0009);
    run_ovf();
    pin_chk("ovf irq on", 0, 1'b1);
    bus_write(st_a, 16'h0020);
    pin_chk("ovf irq masked", 0, 1'b0);
    bus_read(st_a, 16'h00a0, "flag kept");
    bus_write(st_a, 16'h0020);
    bus_read(st_a, 16'h0020, "flag cleared");
    bus_write(st_a, 16'h00a0);
    bus_read(st_a, 16'h0020, "flag write one");
    // A first step taken before break must survive a protected break.
    run_ovf();
    bus_read(st_a, 16'h00e0, "flag armed");
    break_i <= 1'b1;
    bus_write(st_a, 16'h0060);
    pin_chk("flag protected", 0, 1'b1);
    @(posedge clk_i);
    break_i <= 1'b0;
    bus_write(st_a, 16'h0060);
    bus_read(st_a, 16'h0060, "flag after break");
    run_ovf();
    bus_read(st_a, 16'h00e0, "flag armed bce");
    break_i <= 1'b1;
    break_clear_enable_i <= 1'b1;
    bus_write(st_a, 16'h0060);
    @(posedge clk_i);
    break_i <= 1'b0;
    break_clear_enable_i <= 1'b0;
    bus_read(st_a, 16'h0060, "flag cleared in break");
    run_ovf();
    wait_mode_i <= 1'b1;
    pin_chk("wake", 1, 1'b1);
    bus_write(st_a, 16'h0000);
    bus_read(st_a, 16'h0000, "read in wait");
    @(posedge clk_i);
    wait_mode_i <= 1'b0;
    bus_read(st_a, 16'h00e0, "write in wait");
    bus_write(st_a, 16'h0030);
    bus_read(cnt_a, 16'h0000, "counter cleared");
    stop_mode_i <= 1'b1;
    bus_write(st_a, 16'h0000);
    repeat (20) @(posedge clk_i);
    bus_read(cnt_a, 16'h0000, "stop freeze");
    stop_mode_i <= 1'b0;
    break_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    bus_read(cnt_a, 16'h0000, "break freeze");
    break_i <= 1'b0;
    // Unbuffered PWM: clear and set on compare, width rewritten while running.
    for (int e = 0; e < 2; e++)
    begin
      ctl = (e == 0) ? 8'h5a : 8'h5e;
      a = 16'($unsigned($random(seed)) % 4) + 16'h0001;
      bus_write(st_a, 16'h0030);
      bus_write(p0_a, a);
      bus_write(c0_a, {8'h00, ctl});
      bus_write(st_a, 16'h0000);
      measure(0, h1);
      bus_write(p0_a, a + 16'h0004);
      measure(0, h2);
      check("width step", h2 - h1, (e == 0) ? 16'h0028 : 16'hffd8);
      check("ch0 drive", {15'h0000, channel0_pin_oe_n_o}, 16'h0000);
      check("ch0 irq", {15'h0000, chan0_irq_o}, 16'h0001);
    end
    bus_write(c0_a, 16'h0018);
    measure(0, h1);
    check("zero duty", h1, 16'h0000);
    bus_write(c0_a, 16'h0019);
    measure(0, h1);
    check("full duty", h1, 16'h0064);
    // Channel 1 on its own pin, before linking takes that pin away.
    bus_write(p1_a, a);
    bus_write(c1_a, 16'h005a);
    measure(1, h1);
    bus_write(p1_a, a + 16'h0002);
    measure(1, h2);
    check("ch1 width step", h2 - h1, 16'h0014);
    check("ch1 drive", {15'h0000, channel1_pin_oe_n_o}, 16'h0000);
    check("ch1 irq", {15'h0000, chan1_irq_o}, 16'h0001);
    // Buffered PWM: mode_lo is set too, the buffered bit must win.
    bus_write(p0_a, a);
    bus_write(c0_a, 16'h003a);
    measure(0, h1);
    bus_write(p1_a, a + 16'h0004);
    measure(0, h2);
    check("buffered ch1", h2 - h1, 16'h0028);
    check("ch1 released", {15'h0000, channel1_pin_oe_n_o}, 16'h0001);
    check("ch0 drives", {15'h0000, channel0_pin_oe_n_o}, 16'h0000);
    bus_write(p0_a, a + 16'h0002);
    measure(0, h2);
    check("buffered ch0", h2 - h1, 16'h0014);
    repeat (4) @(posedge clk_i);
    complete_run();
  end
endmodule
`default_nettype wire
